// *** print_readout.sv ***
// Purpose: Dual decade counter with frozen serial-by-character printout
// Assumes: Switch, preset and build-option inputs are static while in use
// Notes:   Loop pins and count pulses are synchronised before use
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Selector picks A, B or both
// (R2) Both: A digits, one space, B digits
// (R3) Counts sent one character at a time
// (R4) Each character is 1-2-4-8 BCD
// (R5) Controller paces characters, never self-advancing
// (R6) Most significant decade first, down to least
// (R7) Start comes from controller or previous module
// (R8) Done after last digit; start on upstream done
// (R9) Controller raises print request from several sources
// (R10) Counters frozen at least hold time before printing
// (R11) Lamps blank, each lights as printed
// (R12) Last module's done completes the printout
// (R13) After print: stay frozen or clear and resume
// (R14) A holds seven digits, B six
// (R15) Build option trims A to six digits
// (R16) Local mode ignored unless controller mode off
// (R17) Whole unit is one loop module
// (R18) Cascade B overflow into A: thirteen digits
// (R19) Cascade counting gated by channel B gate
// (R20) Ratio: base preset reached halts both channels
// (R21) Advance pulses step the digit sequencer
// (R22) Data held stable between advance pulses
module print_readout
  import print_readout_pkg::*;
#(
  parameter int unsigned HOLD_TICKS = HOLD_CYCLES
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                count_a_i,
  input  wire logic                count_b_i,
  input  wire logic                gate_b_i,
  input  wire logic                count_enable_i,
  input  wire logic                clear_i,
  input  wire logic                cascade_i,
  input  wire logic [1:0]          ratio_base_i,
  input  wire logic [27:0]         preset_level_i,
  input  wire logic [1:0]          print_select_i,
  input  wire logic                six_digit_a_i,
  input  wire logic                local_recycle_i,
  input  wire logic                ctrl_mode_off_i,
  input  wire logic                ctrl_recycle_i,
  input  wire logic                print_cmd_i,
  input  wire logic                start_transfer_i,
  input  wire logic                advance_i,
  output logic [DIGIT_W-1:0]       data_o,
  output logic                     module_done_o,
  output logic [A_DIGITS-1:0]      lamp_a_o,
  output logic [B_DIGITS-1:0]      lamp_b_o,
  output logic                     counting_o,
  output logic                     overflow_o
);
  typedef struct packed {
    logic [SYNC_W-1:0]                s1;
    logic [SYNC_W-1:0]                s2;
    logic [SYNC_W-1:0]                s3;
    logic [A_DIGITS-1:0][DIGIT_W-1:0] cnt_a;
    logic [B_DIGITS-1:0][DIGIT_W-1:0] cnt_b;
    logic                             ovf;
    logic                             preset_stop;
    phase_t                           phase;
    logic [HOLD_W-1:0]                hold_cnt;
    logic                             start_seen;
    logic                             chan_b;
    logic                             space;
    logic [2:0]                       dig;
    logic [DIGIT_W-1:0]               data;
    logic                             loaded;
    logic                             cur_last;
    logic [LAMPS-1:0]                 lamp;
    logic                             done;
    logic                             counting;
  } state_t;

  state_t        st;
  state_t        next_st;
  char_fifo_if #(.W(CHAR_W)) chars ();

  logic [SYNC_W-1:0] rise;
  logic              send_a;
  logic              send_b;
  logic              recycle;
  logic              push_ok;
  logic              pop_ok;
  logic              is_last;
  logic [3:0]        cur_digit;
  logic [3:0]        cur_lamp;
  logic [CHAR_W-1:0] pop_word;

  // Edges only from the second stage onward
  assign rise = st.s2 & ~st.s3;

  assign send_a  = print_select_i[0]; // see (R1)
  assign send_b  = print_select_i[1]; // see (R1)
  // Controller's mode wins unless it is off
  assign recycle = st.s2[SY_CTRL_OFF] ? local_recycle_i : st.s2[SY_CTRL_REC]; // see (R16)

  // Current character from the frozen counts
  always_comb begin
    cur_digit = st.chan_b ? st.cnt_b[st.dig] : st.cnt_a[st.dig]; // see (R4)
    cur_lamp  = st.chan_b ? (B_LAMP_BASE + {1'b0, st.dig}) : {1'b0, st.dig};
    if (st.space) begin
      cur_digit = SPACE_CHAR; // see (R2)
      cur_lamp  = NO_LAMP;
    end
    is_last = ~st.space && (st.dig == LOW_DIGIT) && (st.chan_b || !send_b);
  end

  assign chars.push_valid = (st.phase == PH_SEND);
  assign chars.push_data  = {is_last, cur_lamp, cur_digit};
  // Only an advance pulse moves past a loaded character
  assign chars.pop_ready  = ((st.phase == PH_SEND) || (st.phase == PH_DRAIN))
                            && (!st.loaded || rise[SY_ADVANCE]); // see (R5)
  assign push_ok  = chars.push_valid & chars.push_ready;
  assign pop_ok   = chars.pop_ready & chars.pop_valid;
  assign pop_word = chars.pop_data;

  always_comb begin
    logic carry_b;
    logic carry_a;
    logic inc_a;
    logic inc_b;
    logic last_taken;
    carry_b    = 1'b0;
    carry_a    = 1'b0;
    inc_a      = 1'b0;
    inc_b      = 1'b0;
    last_taken = 1'b0;
    next_st    = st;

    // Only the second stage reads the first
    next_st.s1 = {ctrl_recycle_i, ctrl_mode_off_i, advance_i,
                  start_transfer_i, print_cmd_i, gate_b_i, count_b_i, count_a_i};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    // Counting stops outside the counting phase
    next_st.counting = (st.phase == PH_COUNT) && !st.preset_stop && count_enable_i; // see (R10)

    // Channel B always obeys its gate, in cascade it gates the whole pair
    inc_b   = st.counting && rise[SY_CNT_B] && st.s2[SY_GATE_B]; // see (R19)
    carry_b = inc_b;
    for (int i = 0; i < B_DIGITS; i++) begin
      if (carry_b) begin
        if (st.cnt_b[i] == BCD_NINE) begin
          next_st.cnt_b[i] = BCD_ZERO;
        end else begin
          next_st.cnt_b[i] = st.cnt_b[i] + 1'b1;
          carry_b          = 1'b0;
        end
      end
    end
    // Cascade feeds B overflow into A for thirteen decades
    inc_a   = cascade_i ? carry_b : (st.counting && rise[SY_CNT_A]); // see (R18)
    carry_a = inc_a;
    for (int i = 0; i < A_DIGITS; i++) begin // see (R14)
      if (carry_a) begin
        if (st.cnt_a[i] == BCD_NINE) begin
          next_st.cnt_a[i] = BCD_ZERO;
        end else begin
          next_st.cnt_a[i] = st.cnt_a[i] + 1'b1;
          carry_a          = 1'b0;
        end
      end
    end
    if (carry_a) begin
      next_st.ovf = 1'b1;
    end

    // Base channel reaching its preset halts both
    if (st.counting) begin
      if ((ratio_base_i == RATIO_BASE_A) && (st.cnt_a == preset_level_i)) begin
        next_st.preset_stop = 1'b1; // see (R20)
      end
      if ((ratio_base_i == RATIO_BASE_B) && (st.cnt_b == preset_level_i[23:0])) begin
        next_st.preset_stop = 1'b1; // see (R20)
      end
    end

    // Output register changes only on a pop, so data stays put in between
    if (pop_ok) begin
      next_st.data     = pop_word[DIGIT_W-1:0]; // see (R22)
      next_st.loaded   = 1'b1;
      next_st.cur_last = pop_word[CH_LAST];
      if (pop_word[CH_LAST-1:CH_LAMP_LO] != NO_LAMP) begin
        next_st.lamp[pop_word[CH_LAST-1:CH_LAMP_LO]] = 1'b1; // see (R11)
      end
    end else if (rise[SY_ADVANCE] && st.loaded && st.cur_last) begin
      last_taken     = 1'b1;
      next_st.loaded = 1'b0;
      next_st.done   = 1'b1; // see (R8) (R12)
    end

    unique case (st.phase)
      PH_COUNT: begin
        if (rise[SY_PRINT]) begin
          next_st.phase      = PH_HOLD;
          next_st.hold_cnt   = '0;
          next_st.start_seen = 1'b0;
          next_st.done       = 1'b0;
        end
      end
      PH_HOLD: begin
        // Upstream done may arrive early; keep it until the hold ends
        if (rise[SY_START]) begin
          next_st.start_seen = 1'b1; // see (R7)
        end
        if (st.hold_cnt != HOLD_W'(HOLD_TICKS - 1)) begin
          next_st.hold_cnt = st.hold_cnt + 1'b1; // see (R10)
        end else if (st.start_seen) begin
          next_st.lamp   = '0; // see (R11)
          next_st.loaded = 1'b0;
          next_st.space  = 1'b0;
          if (print_select_i == SEL_NONE) begin
            next_st.phase = PH_DONE;
            next_st.done  = 1'b1;
          end else begin
            next_st.phase  = PH_SEND;
            next_st.chan_b = !send_a;
            // Trimmed A starts one decade lower
            next_st.dig    = !send_a ? B_TOP_DIGIT :
                             (six_digit_a_i ? A_TRIM_TOP : A_TOP_DIGIT); // see (R6) (R15)
          end
        end
      end
      PH_SEND: begin
        if (push_ok) begin // see (R3)
          if (is_last) begin
            next_st.phase = PH_DRAIN;
          end else if (st.space) begin
            next_st.space  = 1'b0;
            next_st.chan_b = 1'b1;
            next_st.dig    = B_TOP_DIGIT;
          end else if (st.dig == LOW_DIGIT) begin
            next_st.space = 1'b1; // see (R2)
          end else begin
            next_st.dig = st.dig - 1'b1; // see (R6)
          end
        end
      end
      PH_DRAIN: begin
        // One loop module: one start in, one done out
        if (last_taken) begin
          next_st.phase = PH_DONE; // see (R17) (R21)
        end
      end
      PH_DONE: begin
        if (recycle) begin
          next_st.phase       = PH_COUNT; // see (R13)
          next_st.cnt_a       = '0;
          next_st.cnt_b       = '0;
          next_st.ovf         = 1'b0;
          next_st.preset_stop = 1'b0;
          next_st.lamp        = '1;
        end else if (rise[SY_PRINT]) begin
          next_st.phase      = PH_HOLD; // see (R13)
          next_st.hold_cnt   = '0;
          next_st.start_seen = 1'b0;
          next_st.done       = 1'b0;
        end
      end
    endcase

    // System clear ends a frozen result but never cuts a printout short
    if (clear_i && ((st.phase == PH_COUNT) || (st.phase == PH_DONE))) begin
      next_st.phase       = PH_COUNT;
      next_st.cnt_a       = '0;
      next_st.cnt_b       = '0;
      next_st.ovf         = 1'b0;
      next_st.preset_stop = 1'b0;
      next_st.lamp        = '1;
      next_st.done        = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st       <= '0;
      st.phase <= PH_COUNT;
      st.lamp  <= '1;
    end else begin
      st <= next_st;
    end
  end

  char_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .port_i     (chars.fifo_side)
  );

  assign data_o        = st.data;
  assign module_done_o = st.done;
  assign lamp_a_o      = st.lamp[A_DIGITS-1:0];
  assign lamp_b_o      = st.lamp[LAMPS-1:A_DIGITS];
  assign counting_o    = st.counting;
  assign overflow_o    = st.ovf;
endmodule
`default_nettype wire

// *** print_readout_pkg.sv ***
// Purpose: Shared constants and types for the dual counter print readout
// Assumes: 50 MHz core clock
// Notes:   Character word is {last, lamp index, digit}
package print_readout_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned HOLD_MIN_MS = 1000;
  localparam int unsigned HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MIN_MS;
  localparam int          HOLD_W      = 27;

  localparam int A_DIGITS      = 7;
  localparam int A_TRIM_DIGITS = 6;
  localparam int B_DIGITS      = 6;
  localparam int LAMPS         = A_DIGITS + B_DIGITS;
  localparam int DIGIT_W       = 4;

  localparam logic [3:0] BCD_ZERO    = 4'h0;
  localparam logic [3:0] BCD_NINE    = 4'h9;
  localparam logic [3:0] SPACE_CHAR  = 4'hF;
  localparam logic [3:0] NO_LAMP     = 4'hF;
  localparam logic [3:0] B_LAMP_BASE = 4'h7;

  localparam logic [2:0] A_TOP_DIGIT    = 3'h6;
  localparam logic [2:0] A_TRIM_TOP     = 3'h5;
  localparam logic [2:0] B_TOP_DIGIT    = 3'h5;
  localparam logic [2:0] LOW_DIGIT      = 3'h0;

  localparam int CHAR_W     = 9;
  localparam int CH_LAST    = 8;
  localparam int CH_LAMP_LO = 4;
  localparam int FIFO_DEPTH = 8;

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_A    = 2'h1;
  localparam logic [1:0] SEL_B    = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  localparam logic [1:0] RATIO_OFF    = 2'h0;
  localparam logic [1:0] RATIO_BASE_A = 2'h1;
  localparam logic [1:0] RATIO_BASE_B = 2'h2;

  localparam int SY_CNT_A    = 0;
  localparam int SY_CNT_B    = 1;
  localparam int SY_GATE_B   = 2;
  localparam int SY_PRINT    = 3;
  localparam int SY_START    = 4;
  localparam int SY_ADVANCE  = 5;
  localparam int SY_CTRL_OFF = 6;
  localparam int SY_CTRL_REC = 7;
  localparam int SYNC_W      = 8;

  typedef enum logic [2:0] {PH_COUNT, PH_HOLD, PH_SEND, PH_DRAIN, PH_DONE} phase_t;
endpackage

// *** char_fifo_if.sv ***
// Purpose: Valid/ready carrier between the sequencer and its character FIFO
// Assumes: Single clock domain
// Notes:   fifo_side is the FIFO itself; the sequencer fills it
`timescale 1ns/1ps
`default_nettype none
interface char_fifo_if #(parameter int W = 9);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport fifo_side (input push_valid, push_data, pop_ready,
                     output push_ready, pop_valid, pop_data);
  modport user_side (output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// *** char_fifo.sv ***
// Purpose: Small synchronous FIFO for outgoing characters
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic      core_clk_i,
  input  wire logic      rst_i,
  char_fifo_if.fifo_side port_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 used;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        do_push;
  logic        do_pop;

  assign port_i.push_ready = (st.used != (AW+1)'(DEPTH));
  assign port_i.pop_valid  = (st.used != '0);
  assign port_i.pop_data   = st.mem[st.rd];
  assign do_push = port_i.push_valid & port_i.push_ready;
  assign do_pop  = port_i.pop_ready & port_i.pop_valid;

  always_comb begin
    next_st = st;
    if (do_push) begin
      next_st.mem[st.wr] = port_i.push_data;
      next_st.wr         = st.wr + 1'b1;
    end
    if (do_pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    unique case ({do_push, do_pop})
      2'b10:   next_st.used = st.used + 1'b1;
      2'b01:   next_st.used = st.used - 1'b1;
      default: next_st.used = st.used;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// *** print_readout_checker.sv ***
// Purpose: Port-level assertions for print_readout
// Assumes: Selects and recycle modes stay static while a printout runs
// Notes:   Advance age counts cycles since the last advance pin rise
`timescale 1ns/1ps
`default_nettype none
module print_readout_checker
  import print_readout_pkg::*;
#(
  parameter int unsigned HOLD_TICKS = 8
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                count_enable_i,
  input  wire logic [1:0]          print_select_i,
  input  wire logic                local_recycle_i,
  input  wire logic                ctrl_mode_off_i,
  input  wire logic                ctrl_recycle_i,
  input  wire logic                advance_i,
  input  wire logic [DIGIT_W-1:0]  data_o,
  input  wire logic                module_done_o,
  input  wire logic [A_DIGITS-1:0] lamp_a_o,
  input  wire logic [B_DIGITS-1:0] lamp_b_o,
  input  wire logic                counting_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0]  adv_age;
  logic        adv_q;
  logic [31:0] idle;
  wire lamps_on  = &{lamp_a_o, lamp_b_o};
  wire lamps_off = ~|{lamp_a_o, lamp_b_o};
  wire recycle   = ctrl_mode_off_i ? local_recycle_i : ctrl_recycle_i;
  // Window of 8 covers the pin synchroniser plus the output register
  always_ff @(posedge core_clk_i) begin
    adv_q <= advance_i;
    idle  <= (counting_o || rst_i) ? 32'h0000_0000 : idle + 32'h0000_0001;
    if (rst_i) adv_age <= 4'hF;
    else if (advance_i && !adv_q) adv_age <= 4'h0;
    else if (adv_age != 4'hF) adv_age <= adv_age + 4'h1;
  end
  sequence s_stepped;
    adv_age <= 4'h8 || $past(lamps_off);
  endsequence
  sequence s_first_lit;
    lamps_off ##[1:4] $countones({lamp_a_o, lamp_b_o}) == 1;
  endsequence
  a_reset_values: assert property (disable iff (1'b0) rst_i |=> data_o == 4'h0
    && !module_done_o && lamps_on && !counting_o) else $error("Outputs not at reset values");
  a_data_paced: assert property ($changed(data_o) |-> s_stepped)
    else $error("Character changed without an advance");
  a_lamp_stepped: assert property (!lamps_on && $countones({lamp_a_o, lamp_b_o}) >
    $past($countones({lamp_a_o, lamp_b_o})) |-> s_stepped) else $error("Lamp lit unpaced");
  a_blank_start: assert property ($fell(lamps_on) && print_select_i != SEL_NONE
    |-> s_first_lit) else $error("Lamps not blanked then first digit lit");
  a_done_paced: assert property ($rose(module_done_o) && print_select_i != SEL_NONE
    |-> adv_age <= 4'h8) else $error("Done without final advance");
  a_hold_time: assert property ($fell(lamps_on) |-> idle >= HOLD_TICKS - 1)
    else $error("Transfer began before hold time");
  a_bcd_char: assert property (!lamps_on && !lamps_off |-> data_o <= BCD_NINE
    || data_o == SPACE_CHAR) else $error("Character not BCD or space");
  a_recycle_resume: assert property ($rose(module_done_o) && recycle && count_enable_i
    |-> ##[1:4] (counting_o && lamps_on)) else $error("Recycle did not resume counting");
  a_frozen_stay: assert property ($rose(module_done_o) && !recycle
    |=> !counting_o [*4]) else $error("Counting resumed while frozen");
endmodule
bind print_readout print_readout_checker #(.HOLD_TICKS(HOLD_TICKS)) u_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .count_enable_i(count_enable_i),
  .print_select_i(print_select_i), .local_recycle_i(local_recycle_i),
  .ctrl_mode_off_i(ctrl_mode_off_i), .ctrl_recycle_i(ctrl_recycle_i),
  .advance_i(advance_i), .data_o(data_o), .module_done_o(module_done_o),
  .lamp_a_o(lamp_a_o), .lamp_b_o(lamp_b_o), .counting_o(counting_o));
`default_nettype wire

// *** printout_ctrl_model.sv ***
// Purpose: Behavioural printout controller facing one loop module
// Assumes: Start is raised after the print edge so it lands in the hold
// Notes:   Pace adds idle cycles before each character is taken
`timescale 1ns/1ps
`default_nettype none
module printout_ctrl_model #(
  parameter int SETTLE = 30
) (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] data_i,
  input  wire logic       done_i,
  output logic            print_cmd_o,
  output logic            start_o,
  output logic            advance_o
);
  logic [3:0] got[$];
  logic       hung = 1'b0;
  initial begin
    print_cmd_o = 1'b0;
    start_o     = 1'b0;
    advance_o   = 1'b0;
  end
  task automatic run(input int pace);
    int n;
    got.delete();
    @(posedge core_clk_i);
    print_cmd_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    print_cmd_o <= 1'b0;
    start_o     <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    start_o     <= 1'b0;
    for (n = 0; n < 20 && done_i; n++) @(posedge core_clk_i);
    repeat (SETTLE) @(posedge core_clk_i);
    for (n = 0; n < 20 && !done_i; n++) begin
      repeat (pace) @(posedge core_clk_i);
      got.push_back(data_i);
      advance_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      advance_o <= 1'b0;
      repeat (7) @(posedge core_clk_i);
    end
    hung = !done_i;
  endtask
endmodule
`default_nettype wire

// *** test_print_readout.sv ***
// Purpose: Self-checking bench for the print readout
// Assumes: Shortened hold of 8 cycles
// Notes:   Expected digits come from the pulse counts sent, or from the preset in the ratio test
`timescale 1ns/1ps
`default_nettype none
module test_print_readout;
  import print_readout_pkg::*;
  localparam int unsigned HOLD = 8;
  logic       core_clk_i = 1'b0;
  logic       rst_i      = 1'b1;
  logic       count_a    = 1'b0;
  logic       count_b    = 1'b0;
  logic       clear      = 1'b0;
  logic [1:0] sel        = SEL_A;
  logic       trim       = 1'b0;
  logic       local_rc   = 1'b1;
  logic       mode_off   = 1'b0;
  logic       ctrl_rc    = 1'b0;
  logic [1:0] ratio      = RATIO_OFF;
  logic [27:0] preset    = 28'h000_0000;
  int         failures   = 0;
  int         check_count = 0;
  wire  [3:0] data;
  wire        done;
  wire  [6:0] lamp_a;
  wire  [5:0] lamp_b;
  wire        counting;
  wire        overflow;
  wire        print_cmd;
  wire        start;
  wire        advance;
  always #10 core_clk_i = ~core_clk_i;
  print_readout #(.HOLD_TICKS(HOLD)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .count_a_i(count_a), .count_b_i(count_b),
    .gate_b_i(1'b1), .count_enable_i(1'b1), .clear_i(clear), .cascade_i(1'b0),
    .ratio_base_i(ratio), .preset_level_i(preset), .print_select_i(sel),
    .six_digit_a_i(trim), .local_recycle_i(local_rc), .ctrl_mode_off_i(mode_off),
    .ctrl_recycle_i(ctrl_rc), .print_cmd_i(print_cmd), .start_transfer_i(start),
    .advance_i(advance), .data_o(data), .module_done_o(done), .lamp_a_o(lamp_a),
    .lamp_b_o(lamp_b), .counting_o(counting), .overflow_o(overflow));
  printout_ctrl_model model (
    .core_clk_i(core_clk_i), .data_i(data), .done_i(done), .print_cmd_o(print_cmd),
    .start_o(start), .advance_o(advance));
  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Pulses spaced 6 cycles so the synchroniser never merges two edges
  task automatic pulse_counts(input int na, input int nb);
    int i;
    for (i = 0; i < na || i < nb; i++) begin
      count_a <= (i < na);
      count_b <= (i < nb);
      repeat (3) @(posedge core_clk_i);
      count_a <= 1'b0;
      count_b <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
    repeat (6) @(posedge core_clk_i);
  endtask
  task automatic print_and_compare(input logic [1:0] s, input logic t, input int a, input int b,
                                   input int pace, input logic rc);
    logic [3:0] e[$];
    int         i;
    sel  <= s;
    trim <= t;
    @(posedge core_clk_i);
    if (s[0]) for (i = t ? 5 : 6; i >= 0; i--) e.push_back(4'((a / 10 ** i) % 10));
    if (s == SEL_BOTH) e.push_back(SPACE_CHAR);
    if (s[1]) for (i = 5; i >= 0; i--) e.push_back(4'((b / 10 ** i) % 10));
    model.run(pace);
    check("char count", 32'(model.got.size()), 32'(e.size()));
    foreach (e[k]) check("char", 32'(model.got[k]), 32'(e[k]));
    check("module done", 32'(done), 32'h0000_0001);
    for (i = 0; i < 10 && counting !== rc; i++) @(posedge core_clk_i);
    check("counting after print", 32'(counting), 32'(rc));
    if (model.hung || counting !== rc) final_report();
  endtask
  task automatic test_reset();
    @(posedge core_clk_i);
    check("data at reset", 32'(data), 32'h0000_0000);
    check("lamps at reset", 32'({lamp_a, lamp_b}), 32'h0000_1FFF);
    $display("Reset test done");
  endtask
  task automatic test_select_modes();
    pulse_counts(1234, 56);
    print_and_compare(SEL_A, 1'b0, 1234, 56, 0, 1'b0);
    print_and_compare(SEL_B, 1'b0, 1234, 56, 9, 1'b0);
    print_and_compare(SEL_BOTH, 1'b0, 1234, 56, 2, 1'b0);
    print_and_compare(SEL_A, 1'b1, 1234, 56, 0, 1'b0);
    print_and_compare(SEL_NONE, 1'b0, 1234, 56, 0, 1'b0);
    $display("Select modes test done");
  endtask
  task automatic test_clear();
    clear <= 1'b1;
    @(posedge core_clk_i);
    clear <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check("done after clear", 32'(done), 32'h0000_0000);
    $display("Clear test done");
  endtask
  // Local selector set to freeze while the controller asks to recycle
  task automatic test_recycle();
    ctrl_rc  <= 1'b1;
    local_rc <= 1'b0;
    print_and_compare(SEL_BOTH, 1'b0, 0, 0, 0, 1'b1);
    check("lamps after recycle", 32'({lamp_a, lamp_b}), 32'h0000_1FFF);
    pulse_counts(5, 7);
    print_and_compare(SEL_BOTH, 1'b0, 5, 7, 4, 1'b1);
    $display("Recycle test done");
  endtask
  // Base B preset of 3 halts both channels although 10 pulses are sent
  task automatic test_ratio();
    ratio  <= RATIO_BASE_B;
    preset <= 28'h000_0003;
    @(posedge core_clk_i);
    pulse_counts(10, 10);
    check("counting at preset", 32'(counting), 32'h0000_0000);
    check("overflow", 32'(overflow), 32'h0000_0000);
    print_and_compare(SEL_BOTH, 1'b0, 3, 3, 0, 1'b1);
    ratio  <= RATIO_OFF;
    $display("Ratio test done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_select_modes();
    test_clear();
    test_recycle();
    test_ratio();
    final_report();
  end
endmodule
`default_nettype wire
